//--- hdl/core_store_pkg.sv
package core_store_pkg;
    // Store geometry
    localparam int WORD_BITS = 16;
    localparam int WORD_COUNT = 8192;
    localparam int ADDR_BITS = 18;
    localparam int WADDR_BITS = 13;
    localparam int ROW_COUNT = 128;
    localparam int COL_COUNT = 64;
    // Bus address field positions
    localparam int DEV_SEL_HI = 17;
    localparam int DEV_SEL_LO = 14;
    localparam int WADDR_HI = 13;
    localparam int WADDR_LO = 1;
    localparam int BYTE_SEL_BIT = 0;
    // Decode field positions inside the 13-bit word address (bit 1 of bus = index 0)
    localparam int COL_DRV_LO = 0;
    localparam int COL_SW_LO = 3;
    localparam int ROW_DRV_LO = 6;
    localparam int ROW_SW_LO = 9;
    // Reset values
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [3:0] BANK_DEFAULT = 4'h0;

    typedef enum logic [1:0] {
        OP_READ_RESTORE = 2'b00,
        OP_READ_PAUSE = 2'b01,
        OP_WORD_WRITE = 2'b10,
        OP_BYTE_WRITE = 2'b11
    } bus_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_STROBE = 3'b010,
        ST_WRITE = 3'b011,
        ST_DONE = 3'b100
    } cycle_state_t;

    typedef struct packed {
        logic [17:0] addr;
        bus_op_t op;
        logic [15:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [2:0] col_drv;
        logic [2:0] col_sw;
        logic [2:0] row_drv;
        logic [3:0] row_sw;
    } sel_fields_t;
endpackage

//--- hdl/core_word_store.sv
`timescale 1ns/1ps
`default_nettype none
module core_word_store #(
    parameter logic [3:0] BANK_ADDR = core_store_pkg::BANK_DEFAULT
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire core_store_pkg::bus_req_t req,
    output logic ack,
    output logic [15:0] rdata,
    output logic read_dir,
    output logic write_dir,
    output logic [15:0] inhibit,
    output core_store_pkg::sel_fields_t sel,
    output logic pause_flag,
    output logic pause_error
);
    import core_store_pkg::*;

    // Plane array: one word spans all planes, so one index covers every bit
    logic [WORD_BITS-1:0] planes [WORD_COUNT];
    cycle_state_t state;
    bus_op_t op;
    logic [WADDR_BITS-1:0] waddr;
    logic byte_hi;
    logic [15:0] wdata;
    logic [15:0] sensed;
    logic [WADDR_BITS-1:0] pause_addr;
    logic hit;
    logic [15:0] next_inhibit;

    // Field split used for the select outputs
    function automatic sel_fields_t split_addr(input logic [WADDR_BITS-1:0] a);
        sel_fields_t f;
        f.col_drv = a[COL_DRV_LO +: 3];
        f.col_sw = a[COL_SW_LO +: 3];
        f.row_drv = a[ROW_DRV_LO +: 3];
        f.row_sw = a[ROW_SW_LO +: 4];
        return f;
    endfunction

    // Device select compare against the strapped bank
    assign hit = req_valid && (req.addr[DEV_SEL_HI:DEV_SEL_LO] == BANK_ADDR);

    // Request latch; the decoders see only these registers, never the bus
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            op <= OP_READ_RESTORE;
            waddr <= '0;
            byte_hi <= 1'b0;
            wdata <= DATA_RESET;
        end
        else if (clk_en && state == ST_IDLE && hit)
        begin
            op <= req.op;
            waddr <= req.addr[WADDR_HI:WADDR_LO];
            byte_hi <= req.addr[BYTE_SEL_BIT];
            wdata <= req.wdata;
        end
    end

    // Sequencer: read phase, strobe, write phase, done
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
        end
        else if (clk_en)
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (hit)
                    begin
                        // A paused location is already clear, so skip the read
                        if (pause_flag && req.op[1])
                            state <= ST_WRITE;
                        else
                            state <= ST_READ;
                    end
                end
                ST_READ: state <= ST_STROBE;
                ST_STROBE: state <= (op == OP_READ_PAUSE) ? ST_DONE : ST_WRITE;
                ST_WRITE: state <= ST_DONE;
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Destructive read into the sense path, write-back of uninhibited bits
    always_ff @(posedge core_clk)
    begin
        if (clk_en && state == ST_READ)
        begin
            sensed <= planes[waddr];
            planes[waddr] <= '0;
        end
        else if (clk_en && state == ST_WRITE)
        begin
            planes[waddr] <= ~next_inhibit;
        end
    end

    // Data register: strobe for reads, merge for writes
    logic [15:0] next_data;
    always_comb
    begin
        next_data = sensed;
        if (op == OP_WORD_WRITE)
            next_data = wdata;
        else if (op == OP_BYTE_WRITE)
        begin
            if (byte_hi)
                next_data = {wdata[15:8], sensed[7:0]};
            else
                next_data = {sensed[15:8], wdata[7:0]};
        end
    end

    // Inhibit every plane whose new bit is zero
    always_comb
    begin
        next_inhibit = ~rdata;
    end

    // Data register; a pause already left the word here, so merge into it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rdata <= DATA_RESET;
        else if (clk_en && state == ST_IDLE && hit && pause_flag && req.op[1])
        begin
            if (req.op == OP_WORD_WRITE)
                rdata <= req.wdata;
            else if (req.addr[BYTE_SEL_BIT])
                rdata <= {req.wdata[15:8], rdata[7:0]};
            else
                rdata <= {rdata[15:8], req.wdata[7:0]};
        end
        else if (clk_en && state == ST_STROBE)
            rdata <= next_data;
    end

    // Drive controls: direction kept apart from the select fields
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            read_dir <= 1'b0;
            write_dir <= 1'b0;
            inhibit <= '0;
            sel <= '0;
            ack <= 1'b0;
        end
        else if (clk_en)
        begin
            read_dir <= (state == ST_READ);
            write_dir <= (state == ST_WRITE);
            inhibit <= (state == ST_WRITE) ? next_inhibit : '0;
            sel <= split_addr(waddr);
            // Ack rises on entering DONE, so the master drops its request before idle
            ack <= (state == ST_WRITE) || (state == ST_STROBE && op == OP_READ_PAUSE);
        end
    end

    // Pause bookkeeping; a read with the flag still set is the master's fault
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pause_flag <= 1'b0;
            pause_addr <= '0;
            pause_error <= 1'b0;
        end
        else if (clk_en)
        begin
            if (state == ST_STROBE && op == OP_READ_PAUSE)
            begin
                pause_flag <= 1'b1;
                pause_addr <= waddr;
            end
            else if (state == ST_WRITE && op[1])
                pause_flag <= 1'b0;
            if (state == ST_IDLE && hit && pause_flag &&
                (!req.op[1] || req.addr[WADDR_HI:WADDR_LO] != pause_addr))
                pause_error <= 1'b1;
        end
    end

    // Phase markers shared by the checks below
    sequence s_read_phase;
        state == ST_READ;
    endsequence

    sequence s_write_phase;
        state == ST_WRITE;
    endsequence

    sequence s_strobe_phase;
        clk_en ##0 state == ST_STROBE;
    endsequence

    sequence s_fresh_take;
        clk_en ##0 state == ST_IDLE && hit && !(pause_flag && req.op[1]);
    endsequence

    // Drive and inhibit checks
    a_inhibit_write_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        (inhibit != 16'h0000) |-> write_dir)
        else $error("inhibit outside write phase");
    a_dir_exclusive: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(read_dir && write_dir))
        else $error("both directions driven");
    a_read_dir_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 s_read_phase |=> read_dir && inhibit == 16'h0000)
        else $error("inhibit during read phase");
    a_write_data: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 s_write_phase |=>
        planes[$past(waddr)] == $past(rdata) && inhibit == ~$past(rdata))
        else $error("written word mismatch");

    // Store and data register checks
    a_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 s_read_phase |=> planes[$past(waddr)] == 16'h0000)
        else $error("read did not clear word");
    a_strobe_loads: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_strobe_phase ##0 !op[1] |=> rdata == $past(sensed))
        else $error("strobe did not load data register");
    a_byte_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_strobe_phase ##0 op == OP_BYTE_WRITE |=> (byte_hi ?
        rdata[7:0] == $past(sensed[7:0]) : rdata[15:8] == $past(sensed[15:8])))
        else $error("unselected byte lost");

    // Sequencing checks; pairing a pause is the master's duty, the flag only records it
    a_fresh_reads_first: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_fresh_take |=> s_read_phase)
        else $error("write did not clear first");
    a_write_follows_strobe: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state == ST_STROBE && op == OP_READ_RESTORE |=> s_write_phase)
        else $error("restore write missing");
    a_pause_skips_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state == ST_IDLE && hit && pause_flag && req.op[1] |=> s_write_phase)
        else $error("paused write did not skip read");
    a_pause_sets_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state == ST_STROBE && op == OP_READ_PAUSE |=> pause_flag && state == ST_DONE)
        else $error("pause flag not set");
    a_pause_cleared: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 s_write_phase |=> !pause_flag)
        else $error("pause flag not cleared");
    a_pause_error_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        pause_error |=> pause_error)
        else $error("pause error dropped");
    a_miss_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == ST_IDLE && !hit |=> state == ST_IDLE)
        else $error("responded to other bank");
    a_ack_after_done: assert property (@(posedge core_clk) disable iff (sys_rst)
        ack == (state == ST_DONE))
        else $error("ack not aligned with done");
    a_ack_one_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 ack |=> !ack)
        else $error("ack held too long");

    // Address path checks
    a_take_latches: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en ##0 state == ST_IDLE && hit |=>
        waddr == $past(req.addr[WADDR_HI:WADDR_LO]) && byte_hi == $past(req.addr[BYTE_SEL_BIT]))
        else $error("request address not latched");
    a_addr_latched: assert property (@(posedge core_clk) disable iff (sys_rst)
        state != ST_IDLE |=> $stable(waddr))
        else $error("word address moved mid-cycle");
    a_sel_tracks: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en |=> sel == split_addr($past(waddr)))
        else $error("select fields not from latched address");
endmodule
`default_nettype wire

//--- test/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import core_store_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire core_store_pkg::bus_req_t cmd,
    input wire logic ack,
    output logic req_valid,
    output core_store_pkg::bus_req_t req,
    output logic done
);
    // Request held whole until ack or until go falls, dropped in the ack cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            req_valid <= 1'b0;
            req <= '0;
            done <= 1'b0;
        end
        else if (req_valid && (ack || !go))
        begin
            req_valid <= 1'b0;
            req <= ~req;  // Released bus must not keep showing the old value
            done <= ack;
        end
        else
        begin
            done <= 1'b0;
            if (go && !req_valid && !done)
            begin
                req_valid <= 1'b1;
                req <= cmd;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/core_word_store_addressing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module core_word_store_addressing_tb;
    import core_store_pkg::*;
    typedef struct packed {bus_op_t op; logic [17:0] a; logic [15:0] wd; logic [15:0] ex;} row_t;
    localparam int N = 15;
    // Operation, address, bus data, word expected in the data register afterwards
    localparam row_t ROWS [N] = '{
        '{OP_WORD_WRITE, 18'h0_0010, 16'h1234, 16'h1234},
        '{OP_READ_RESTORE, 18'h0_0010, 16'h0000, 16'h1234},
        '{OP_READ_RESTORE, 18'h0_0010, 16'h0000, 16'h1234},
        '{OP_BYTE_WRITE, 18'h0_0011, 16'hABAB, 16'hAB34},
        '{OP_BYTE_WRITE, 18'h0_0010, 16'hCDCD, 16'hABCD},
        '{OP_WORD_WRITE, 18'h0_3FFF, 16'h8001, 16'h8001},
        '{OP_READ_RESTORE, 18'h0_0010, 16'h0000, 16'hABCD},
        '{OP_READ_RESTORE, 18'h0_3FFE, 16'h0000, 16'h8001},
        '{OP_WORD_WRITE, 18'h0_0020, 16'h5555, 16'h5555},
        '{OP_READ_PAUSE, 18'h0_0020, 16'h0000, 16'h5555},  // Paired write next
        '{OP_WORD_WRITE, 18'h0_0020, 16'h0F0F, 16'h0F0F},
        '{OP_READ_RESTORE, 18'h0_0020, 16'h0000, 16'h0F0F},
        '{OP_READ_PAUSE, 18'h0_0020, 16'h0000, 16'h0F0F},  // Paired byte write next
        '{OP_BYTE_WRITE, 18'h0_0021, 16'hA5A5, 16'hA50F},
        '{OP_READ_RESTORE, 18'h0_0020, 16'h0000, 16'hA50F}
    };
    logic core_clk = 0, sys_rst = 1, clk_en = 1, go = 0;
    logic req_valid, ack, done, read_dir, write_dir, pause_flag, pause_error;
    logic [15:0] rdata, inhibit;
    bus_req_t cmd = '0, req;
    sel_fields_t sel;
    int bad_count = 0, samples_checked = 0;
    core_word_store DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .ack(ack), .rdata(rdata), .read_dir(read_dir),
        .write_dir(write_dir), .inhibit(inhibit), .sel(sel), .pause_flag(pause_flag),
        .pause_error(pause_error));
    bus_master_model master (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .cmd(cmd),
        .ack(ack), .req_valid(req_valid), .req(req), .done(done));
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic logic [15:0] exp_sel(input logic [17:0] a);
        return {3'h0, a[3:1], a[6:4], a[9:7], a[13:10]};
    endfunction
    task automatic end_of_test();
        $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One request through the master; inhibit watched in the read and write phases
    task automatic run(input row_t r, input int lim, output logic acked);
        int n;
        n = 0;
        cmd <= '{r.a, r.op, r.wd};
        go <= 1'b1;
        while (!done && n < lim)
        begin
            @(posedge core_clk);
            n++;
            if (read_dir) cmp_word(inhibit, 16'h0000);
            if (write_dir) cmp_word(inhibit, ~r.ex);
        end
        acked = done;
        go <= 1'b0;
        @(posedge core_clk);
    endtask
    // Free-running clock, 50 ns period
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #(3000 * 50);
        bad_count++;
        end_of_test();
    end
    // Table pass, then foreign bank, unpaired pause and mid-run reset
    initial
    begin
        logic ok;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        cmp_word(rdata, DATA_RESET);
        cmp_flag(pause_flag, 1'b0);
        for (int i = 0; i < N; i++)
        begin
            run(ROWS[i], 12, ok);
            cmp_flag(ok, 1'b1);
            cmp_word({3'h0, sel}, exp_sel(ROWS[i].a));
            if (ROWS[i].op inside {OP_READ_RESTORE, OP_READ_PAUSE})
                cmp_word(rdata, ROWS[i].ex);
            cmp_flag(pause_flag, ROWS[i].op == OP_READ_PAUSE);
        end
        run('{OP_WORD_WRITE, 18'h0_4010, 16'hFFFF, 16'h0000}, 20, ok);
        cmp_flag(ok, 1'b0);
        run('{OP_READ_RESTORE, 18'h0_0010, 16'h0000, 16'hABCD}, 12, ok);
        cmp_word(rdata, 16'hABCD);
        run('{OP_READ_PAUSE, 18'h0_0010, 16'h0000, 16'hABCD}, 12, ok);
        run('{OP_WORD_WRITE, 18'h0_0030, 16'h7777, 16'h7777}, 12, ok);
        cmp_flag(pause_error, 1'b1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        cmp_flag(pause_error, 1'b0);
        run('{OP_READ_RESTORE, 18'h0_3FFE, 16'h0000, 16'h8001}, 12, ok);
        cmp_word(rdata, 16'h8001);
        // Frozen clock enable: the request must wait untaken
        clk_en <= 1'b0;
        run('{OP_READ_RESTORE, 18'h0_0030, 16'h0000, 16'h7777}, 6, ok);
        cmp_flag(ok, 1'b0);
        cmp_word(rdata, 16'h8001);
        clk_en <= 1'b1;
        run('{OP_READ_RESTORE, 18'h0_0030, 16'h0000, 16'h7777}, 12, ok);
        cmp_flag(ok, 1'b1);
        cmp_word(rdata, 16'h7777);
        end_of_test();
    end
endmodule
`default_nettype wire
